// file: hdl/mer_pkg.sv
// shared constants and types for the media error recovery policy block
package mer_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int LIMIT_UNIT_MS = 1;
    localparam logic [15:0] LIMIT_MIN_MS = 16'h0028;
    localparam logic [15:0] LIMIT_MAX_MS = 16'hFFFF;
    localparam logic [7:0] DEFAULT_MAX_PASSES = 8'h08;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_RETRY = 5'h04;
    localparam logic [4:0] OFS_TLIMIT = 5'h08;
    localparam logic [4:0] OFS_COMMIT = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    localparam logic [4:0] OFS_INFO = 5'h14;
    localparam logic [4:0] OFS_COUNT = 5'h18;
    localparam int CTRL_POST_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_PASS_BIT = 2;
    localparam int CTRL_RC_BIT = 3;
    localparam int CTRL_MAX_BIT = 4;
    localparam int CTRL_WCE_BIT = 5;
    localparam int RETRY_RD_LSB = 0;
    localparam int RETRY_WR_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_CHECK_BIT = 1;
    localparam int STAT_SOFT_BIT = 2;
    localparam int STAT_HARD_BIT = 3;
    localparam int STAT_KEY_LSB = 4;
    localparam logic [7:0] READ_RETRY_RST = 8'h01;
    localparam logic [7:0] WRITE_RETRY_RST = 8'h01;
    localparam logic [15:0] TLIMIT_RST = 16'h0000;
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_RECOVERED = 4'h1;
    localparam logic [3:0] KEY_MEDIUM = 4'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic postError;
        logic stopOnRecoveredError;
        logic passUnrecoveredBlock;
        logic continuousReadFlag;
        logic retryCountAsMax;
        logic writeCachingOn;
        logic [7:0] readRetry;
        logic [7:0] writeRetry;
        logic [15:0] limitMs;
    } mer_cfg_t;

    localparam mer_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        READ_RETRY_RST, WRITE_RETRY_RST, TLIMIT_RST};

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_RECOV} mer_state_t;
endpackage

// file: hdl/mer_policy.sv
// error recovery policy controller with its register slave
// Functional notes
// - post-error set reports recovered errors
// - stop flag halts transfer at first recovered
// - read retry count caps passes; zero disables
// - max bit: count is ceiling, else all steps
// - write retry count caps passes; zero disables
// - time limit in milliseconds, 40 to 65535; values below 40 are stored and used unchecked
// - timer advances in 50 ms steps
// - timeout on a block ends with check condition
// - no timer for cached writes or zero limit
// - illegal flag mix accepted without failure
// - clean or continued transfers send full length
// - hard error, flag clear: withhold block, check
// - hard error, pass flag, no post: send block
// - post-error: check with recovered key at end
// - post-error, no stop: info holds last recovered
// - post and stop: stop, info holds that block
// - continuous read overrides, no recovery delays
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module mer_policy
    import mer_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter logic [7:0] MAX_PASSES = DEFAULT_MAX_PASSES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // command from the command engine
    input wire logic cmdStart,
    input wire logic cmdRead,
    input wire logic [15:0] cmdLen,
    // block results from the medium engine
    input wire logic blkReady,
    input wire logic blkErr,
    input wire logic [31:0] blkLba,
    input wire logic passDone,
    input wire logic passOk,
    // actions toward medium and host
    output logic retryReq,
    output logic blkSend,
    output logic cmdDone,
    output logic checkCond,
    output logic [3:0] senseKey,
    output logic [31:0] senseInfo
);
    typedef struct packed {
        logic awRdy;
        logic wRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arRdy;
        logic rValid;
        logic [1:0] rResp;
        logic [31:0] rData;
        logic awHeld;
        logic wHeld;
        logic [4:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        mer_cfg_t shadow;
        mer_cfg_t active;
        mer_state_t fsm;
        logic isRead;
        logic [15:0] len;
        logic [15:0] sent;
        logic [31:0] curLba;
        logic [7:0] passes;
        logic [7:0] limit;
        logic softSeen;
        logic hardErr;
        logic [31:0] lastSoft;
        logic retryReq;
        logic blkSend;
        logic cmdDone;
        logic checkCond;
        logic [3:0] senseKey;
        logic [31:0] senseInfo;
    } mer_state_reg_t;

    mer_state_reg_t s_reg, n;
    mer_tmr_if tmr();

    mer_recovery_timer #(.TICK_LEN(TICK_LEN)) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .tmr(tmr)
    );

    // the timer sees the next state so a stale expiry never meets a fresh block
    assign tmr.start = n.retryReq && s_reg.fsm != ST_RECOV;
    assign tmr.limitMs = s_reg.active.limitMs;
    assign tmr.enable = s_reg.active.limitMs != 16'h0000 && !(!s_reg.isRead && s_reg.active.writeCachingOn);

    assign s_axi_awready = s_reg.awRdy;
    assign s_axi_wready = s_reg.wRdy;
    assign s_axi_bvalid = s_reg.bValid;
    assign s_axi_bresp = s_reg.bResp;
    assign s_axi_arready = s_reg.arRdy;
    assign s_axi_rvalid = s_reg.rValid;
    assign s_axi_rresp = s_reg.rResp;
    assign s_axi_rdata = s_reg.rData;
    assign retryReq = s_reg.retryReq;
    assign blkSend = s_reg.blkSend;
    assign cmdDone = s_reg.cmdDone;
    assign checkCond = s_reg.checkCond;
    assign senseKey = s_reg.senseKey;
    assign senseInfo = s_reg.senseInfo;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] wr;
    logic [7:0] passCap;
    logic hardNow;

    always_comb begin
        n = s_reg;
        wr = '0;
        n.retryReq = 1'b0;
        n.blkSend = 1'b0;
        n.cmdDone = 1'b0;
        // register writes: address and data in either order, answer after both
        if (s_axi_awvalid && s_reg.awRdy) begin
            n.awHeld = 1'b1;
            n.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_reg.wRdy) begin
            n.wHeld = 1'b1;
            n.wData = s_axi_wdata;
            n.wStrb = s_axi_wstrb;
        end
        if (s_reg.bValid && s_axi_bready) begin
            n.bValid = 1'b0;
        end
        if (s_reg.awHeld && s_reg.wHeld && !s_reg.bValid) begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bValid = 1'b1;
            n.bResp = RESP_OKAY;
            case ({s_reg.awAddr[4:2], 2'b00})
                OFS_CTRL: begin
                    wr = merge({26'h0, s_reg.shadow.writeCachingOn, s_reg.shadow.retryCountAsMax,
                        s_reg.shadow.continuousReadFlag, s_reg.shadow.passUnrecoveredBlock,
                        s_reg.shadow.stopOnRecoveredError, s_reg.shadow.postError}, s_reg.wData, s_reg.wStrb);
                    // an illegal stop-without-post mix is stored as written, never refused
                    n.shadow.postError = wr[CTRL_POST_BIT];
                    n.shadow.stopOnRecoveredError = wr[CTRL_STOP_BIT];
                    n.shadow.passUnrecoveredBlock = wr[CTRL_PASS_BIT];
                    n.shadow.continuousReadFlag = wr[CTRL_RC_BIT];
                    n.shadow.retryCountAsMax = wr[CTRL_MAX_BIT];
                    n.shadow.writeCachingOn = wr[CTRL_WCE_BIT];
                end
                OFS_RETRY: begin
                    wr = merge({16'h0, s_reg.shadow.writeRetry, s_reg.shadow.readRetry}, s_reg.wData, s_reg.wStrb);
                    n.shadow.readRetry = wr[RETRY_RD_LSB +: 8];
                    n.shadow.writeRetry = wr[RETRY_WR_LSB +: 8];
                end
                OFS_TLIMIT: begin
                    wr = merge({16'h0, s_reg.shadow.limitMs}, s_reg.wData, s_reg.wStrb);
                    n.shadow.limitMs = wr[15:0];
                end
                OFS_COMMIT: begin
                    n.active = s_reg.shadow;
                end
                OFS_STATUS, OFS_INFO, OFS_COUNT: begin
                    n.bResp = RESP_OKAY;
                end
                default: begin
                    n.bResp = RESP_SLVERR;
                end
            endcase
        end
        n.awRdy = !n.awHeld && !n.bValid;
        n.wRdy = !n.wHeld && !n.bValid;
        // register reads
        if (s_reg.rValid && s_axi_rready) begin
            n.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_reg.arRdy) begin
            n.rValid = 1'b1;
            n.rResp = RESP_OKAY;
            case ({s_axi_araddr[4:2], 2'b00})
                OFS_CTRL: n.rData = {26'h0, s_reg.shadow.writeCachingOn, s_reg.shadow.retryCountAsMax,
                    s_reg.shadow.continuousReadFlag, s_reg.shadow.passUnrecoveredBlock,
                    s_reg.shadow.stopOnRecoveredError, s_reg.shadow.postError};
                OFS_RETRY: n.rData = {16'h0, s_reg.shadow.writeRetry, s_reg.shadow.readRetry};
                OFS_TLIMIT: n.rData = {16'h0, s_reg.shadow.limitMs};
                OFS_COMMIT: n.rData = '0;
                OFS_STATUS: n.rData = {24'h0, s_reg.senseKey, s_reg.hardErr, s_reg.softSeen,
                    s_reg.checkCond, s_reg.fsm != ST_IDLE};
                OFS_INFO: n.rData = s_reg.senseInfo;
                OFS_COUNT: n.rData = {16'h0, s_reg.sent};
                default: begin
                    n.rData = '0;
                    n.rResp = RESP_SLVERR;
                end
            endcase
        end
        n.arRdy = !n.rValid;
        // recovery pass cap for the running command
        if (s_reg.isRead) begin
            passCap = s_reg.active.readRetry == 8'h00 ? 8'h00 :
                (s_reg.active.retryCountAsMax ? s_reg.active.readRetry : MAX_PASSES);
        end else begin
            passCap = s_reg.active.writeRetry;
        end
        hardNow = 1'b0;
        // policy sequencer
        case (s_reg.fsm)
            ST_IDLE: begin
                if (cmdStart) begin
                    n.fsm = ST_XFER;
                    n.isRead = cmdRead;
                    n.len = cmdLen;
                    n.sent = '0;
                    n.softSeen = 1'b0;
                    n.hardErr = 1'b0;
                    n.checkCond = 1'b0;
                    n.senseKey = KEY_NONE;
                    n.senseInfo = '0;
                end
            end
            ST_XFER: begin
                if (s_reg.sent == s_reg.len) begin
                    n.fsm = ST_IDLE;
                    n.cmdDone = 1'b1;
                    // recovered errors only surface when posting is on
                    n.checkCond = s_reg.active.postError && s_reg.softSeen;
                    n.senseKey = n.checkCond ? KEY_RECOVERED : KEY_NONE;
                    n.senseInfo = n.checkCond ? s_reg.lastSoft : '0;
                end else if (blkReady) begin
                    n.curLba = blkLba;
                    if (!blkErr || (s_reg.isRead && s_reg.active.continuousReadFlag)) begin
                        n.blkSend = 1'b1;
                        n.sent = s_reg.sent + 16'h0001;
                    end else if (passCap == 8'h00) begin
                        hardNow = 1'b1;
                    end else begin
                        n.fsm = ST_RECOV;
                        n.passes = 8'h00;
                        n.limit = passCap;
                        n.retryReq = 1'b1;
                    end
                end
            end
            ST_RECOV: begin
                if (passDone && passOk) begin
                    n.blkSend = 1'b1;
                    n.sent = s_reg.sent + 16'h0001;
                    n.softSeen = 1'b1;
                    n.lastSoft = s_reg.curLba;
                    if (s_reg.active.stopOnRecoveredError) begin
                        n.fsm = ST_IDLE;
                        n.cmdDone = 1'b1;
                        n.checkCond = s_reg.active.postError;
                        n.senseKey = s_reg.active.postError ? KEY_RECOVERED : KEY_NONE;
                        n.senseInfo = s_reg.curLba;
                    end else begin
                        n.fsm = ST_XFER;
                    end
                end else if (passDone && s_reg.passes + 8'h01 < s_reg.limit) begin
                    n.passes = s_reg.passes + 8'h01;
                    n.retryReq = 1'b1;
                end else if (passDone || tmr.expired) begin
                    hardNow = 1'b1;
                end
            end
            default: begin
                n.fsm = ST_IDLE;
            end
        endcase
        if (hardNow) begin
            n.fsm = ST_IDLE;
            n.cmdDone = 1'b1;
            n.hardErr = 1'b1;
            n.blkSend = s_reg.active.passUnrecoveredBlock && !s_reg.active.postError;
            n.checkCond = 1'b1;
            n.senseKey = KEY_MEDIUM;
            n.senseInfo = n.curLba;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '{shadow: CFG_RST, active: CFG_RST, fsm: ST_IDLE, default: '0};
        end else begin
            s_reg <= n;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_lastPassFails;
        s_reg.fsm == ST_RECOV && passDone && !passOk && s_reg.passes + 8'h01 >= s_reg.limit;
    endsequence
    sequence s_softRecovered;
        s_reg.fsm == ST_RECOV && passDone && passOk;
    endsequence

    a_clean_block_sent: assert property (s_reg.fsm == ST_XFER && s_reg.sent != s_reg.len && blkReady && !blkErr
        |=> blkSend && !retryReq ##1 !blkSend)
        else $error("clean block not sent");
    a_rc_no_retry: assert property (s_reg.fsm == ST_XFER && s_reg.sent != s_reg.len && blkReady && blkErr
        && s_reg.isRead && s_reg.active.continuousReadFlag |=> blkSend && !retryReq && s_reg.fsm == ST_XFER)
        else $error("continuous read stalled for recovery");
    a_pass_cap_held: assert property (s_reg.fsm == ST_RECOV |-> s_reg.passes < s_reg.limit && s_reg.limit != 8'h00)
        else $error("recovery ran beyond its pass cap");
    a_timeout_check: assert property (s_reg.fsm == ST_RECOV && tmr.expired && !passDone
        |=> cmdDone && checkCond && senseKey == KEY_MEDIUM && senseInfo == $past(s_reg.curLba))
        else $error("timeout did not end with check condition");
    a_hard_withheld: assert property (s_lastPassFails ##0 !s_reg.active.passUnrecoveredBlock
        |=> cmdDone && !blkSend && checkCond ##1 s_reg.fsm == ST_IDLE)
        else $error("unrecovered block leaked or status missing");
    a_hard_passed: assert property (s_lastPassFails ##0 s_reg.active.passUnrecoveredBlock && !s_reg.active.postError
        |=> cmdDone && blkSend && checkCond)
        else $error("unrecovered block not passed to host");
    a_stop_first_soft: assert property (s_softRecovered ##0 s_reg.active.stopOnRecoveredError
        |=> cmdDone && blkSend && senseInfo == $past(s_reg.curLba))
        else $error("transfer not stopped at first recovered block");
    a_soft_continues: assert property (s_softRecovered ##0 !s_reg.active.stopOnRecoveredError
        |=> blkSend && !cmdDone && s_reg.fsm == ST_XFER)
        else $error("transfer stopped on recovered error");
    a_quiet_recovered: assert property (cmdDone && !s_reg.hardErr && !s_reg.active.postError |-> !checkCond)
        else $error("recovered errors posted with posting off");
    a_post_recovered: assert property (cmdDone && !s_reg.hardErr && s_reg.active.postError && s_reg.softSeen
        |-> checkCond && senseKey == KEY_RECOVERED)
        else $error("recovered error not posted");
    a_commit_latch: assert property (s_reg.awHeld && s_reg.wHeld && !s_reg.bValid
        && {s_reg.awAddr[4:2], 2'b00} == OFS_COMMIT |=> s_reg.active == $past(s_reg.shadow))
        else $error("commit did not latch settings");
endmodule

// file: hdl/mer_recovery_timer.sv
// per-block recovery timer with coarse millisecond steps
`timescale 1ns/1ps
module mer_recovery_timer
    import mer_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    mer_tmr_if.timer tmr
);
    localparam int CW = $clog2(TICK_LEN + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [16:0] elapsedMs;
        logic running;
        logic expired;
    } mer_tmr_state_t;

    mer_tmr_state_t s_reg, s_next;
    logic [16:0] stepped;

    assign tmr.expired = s_reg.expired;

    always_comb begin
        s_next = s_reg;
        stepped = s_reg.elapsedMs + 17'(TICK_MS);
        if (tmr.start) begin
            s_next.cnt = '0;
            s_next.elapsedMs = '0;
            s_next.running = tmr.enable;
            s_next.expired = 1'b0;
        end else if (s_reg.running) begin
            // time only advances in whole steps, so expiry can land up to one step late
            if (s_reg.cnt == CW'(TICK_LEN - 1)) begin
                s_next.cnt = '0;
                s_next.elapsedMs = stepped;
                if (stepped >= {1'b0, tmr.limitMs}) begin
                    s_next.expired = 1'b1;
                    s_next.running = 1'b0;
                end
            end else begin
                s_next.cnt = s_reg.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    a_timer_step: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_reg.expired) |-> s_reg.elapsedMs >= {1'b0, tmr.limitMs} && s_reg.elapsedMs[0] == 1'b0 &&
            $past(s_reg.cnt) == CW'(TICK_LEN - 1))
        else $error("timer expired off a step boundary");
endmodule

// file: hdl/mer_tmr_if.sv
// carrier between the policy controller and its recovery timer
`timescale 1ns/1ps
interface mer_tmr_if;
    logic start;
    logic enable;
    logic [15:0] limitMs;
    logic expired;
    modport owner(output start, output enable, output limitMs, input expired);
    modport timer(input start, input enable, input limitMs, output expired);
endinterface

// file: sim/media_error_recovery_policy_tb_top.sv
// policy block testbench driving commands and register writes
`timescale 1ns/1ps
module media_error_recovery_policy_tb_top import mer_pkg::*;;
    logic ref_clk, rst, cmdStart, cmdRead, blkReady, blkErr, passDone, passOk;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic retryReq, blkSend, cmdDone, checkCond;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, blkLba, senseInfo, rdVal;
    logic [3:0] s_axi_wstrb, senseKey, failCount;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] cmdLen;
    logic [7:0] passDelay;
    int n_errors, samples_checked, nSend, nRetry, testNo;
    // short tick keeps the 50 ms steps affordable in simulation
    mer_policy #(.TICK_LEN(4)) u_dut (.*);
    mer_medium_model u_med (.*);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (blkSend === 1'b1) nSend++;
        if (retryReq === 1'b1) nRetry++;
    end
    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task hang;
        n_errors++;
        report_and_stop();
    endtask
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // bready and rready stay high, so each answer is taken at once
    task axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (k == 100) hang();
        check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task axi_rd(input logic [4:0] a, input logic [1:0] er);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (k == 100) hang();
        rdVal = s_axi_rdata;
        check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    task scen(input logic [5:0] ctl, input logic [15:0] rty, input logic [15:0] lim, input int cm,
        input int rd, input int len, input logic [3:0] msk, input int fl, input int dl,
        input int eSend, input int eRetry, input int eChk, input logic [3:0] eKey, input logic [31:0] eInfo);
        int i, k;
        logic done;
        axi_wr(OFS_CTRL, {26'h0, ctl}, RESP_OKAY);
        axi_wr(OFS_RETRY, {16'h0, rty}, RESP_OKAY);
        axi_wr(OFS_TLIMIT, {16'h0, lim}, RESP_OKAY);
        if (cm) axi_wr(OFS_COMMIT, 32'h0, RESP_OKAY);
        failCount <= 4'(fl);
        passDelay <= 8'(dl);
        nSend = 0;
        nRetry = 0;
        done = 1'b0;
        cmdStart <= 1'b1;
        cmdRead <= (rd != 0);
        cmdLen <= len[15:0];
        @(posedge ref_clk);
        cmdStart <= 1'b0;
        for (i = 0; i < len && !done; i++) begin
            blkReady <= 1'b1;
            blkErr <= msk[i];
            blkLba <= 32'h10 + i;
            @(posedge ref_clk);
            blkReady <= 1'b0;
            for (k = 0; k < 100; k++) begin
                @(posedge ref_clk);
                done = (cmdDone === 1'b1);
                if (blkSend === 1'b1 || done) break;
            end
            if (k == 100) hang();
        end
        for (k = 0; k < 100 && !done; k++) begin
            @(posedge ref_clk);
            done = (cmdDone === 1'b1);
        end
        if (!done) hang();
        repeat (2) @(posedge ref_clk);
        check("sent", eSend, nSend);
        check("retries", eRetry, nRetry);
        check("check", eChk, {31'h0, checkCond});
        check("key", {28'h0, eKey}, {28'h0, senseKey});
        if (eChk) check("info", eInfo, senseInfo);
        // status and info registers must mirror the status pins once idle
        axi_rd(OFS_STATUS, RESP_OKAY);
        check("status", {24'h0, eKey, 2'b00, eChk[0], 1'b0}, rdVal & 32'h000000F3);
        axi_rd(OFS_INFO, RESP_OKAY);
        if (eChk) check("info reg", eInfo, rdVal);
        // a late pass result from the model must die out before the next command
        repeat (40) @(posedge ref_clk);
        testNo++;
        $display("test %0d done", testNo);
    endtask
    initial begin
        {n_errors, samples_checked, testNo} = '0;
        {cmdStart, cmdRead, blkReady, blkErr, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, blkLba, cmdLen} = '0;
        {s_axi_bready, s_axi_rready, rst} = 3'h7;
        s_axi_wstrb = 4'hF;
        failCount = 4'h0;
        passDelay = 8'h01;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        axi_rd(OFS_CTRL, RESP_OKAY);
        check("ctrl", 32'h0, rdVal);
        axi_rd(OFS_RETRY, RESP_OKAY);
        check("retry", 32'h0101, rdVal);
        axi_rd(5'h1C, RESP_SLVERR);
        axi_wr(5'h1C, 32'h0, RESP_SLVERR);
        axi_wr(OFS_CTRL, 32'h2, RESP_OKAY);
        axi_wr(OFS_COMMIT, 32'h0, RESP_OKAY);
        scen(6'h00, 16'h0101, 16'h0, 1, 1, 3, 4'h0, 0, 1, 3, 0, 0, KEY_NONE, 0);
        scen(6'h00, 16'h0102, 16'h0, 1, 1, 3, 4'h2, 3, 2, 3, 4, 0, KEY_NONE, 0);
        scen(6'h10, 16'h0102, 16'h0, 1, 1, 3, 4'h2, 3, 2, 1, 2, 1, KEY_MEDIUM, 32'h11);
        scen(6'h01, 16'h0101, 16'h0, 1, 1, 3, 4'h3, 0, 2, 3, 2, 1, KEY_RECOVERED, 32'h11);
        scen(6'h00, 16'h0101, 16'h0, 0, 1, 2, 4'h2, 0, 2, 2, 1, 1, KEY_RECOVERED, 32'h11);
        scen(6'h03, 16'h0101, 16'h0, 1, 1, 3, 4'h2, 0, 2, 2, 1, 1, KEY_RECOVERED, 32'h11);
        scen(6'h00, 16'h0100, 16'h0, 1, 1, 3, 4'h2, 0, 2, 1, 0, 1, KEY_MEDIUM, 32'h11);
        scen(6'h04, 16'h0100, 16'h0, 1, 1, 3, 4'h2, 0, 2, 2, 0, 1, KEY_MEDIUM, 32'h11);
        scen(6'h00, 16'h0001, 16'h0, 1, 0, 2, 4'h1, 0, 2, 0, 0, 1, KEY_MEDIUM, 32'h10);
        scen(6'h04, 16'h0201, 16'h0, 1, 0, 1, 4'h1, 3, 2, 1, 2, 1, KEY_MEDIUM, 32'h10);
        scen(6'h09, 16'h0101, 16'h0, 1, 1, 3, 4'h7, 0, 2, 3, 0, 0, KEY_NONE, 0);
        scen(6'h00, 16'h0101, 16'h0028, 1, 1, 2, 4'h2, 0, 30, 1, 1, 1, KEY_MEDIUM, 32'h11);
        scen(6'h00, 16'h0101, 16'h0032, 1, 1, 2, 4'h2, 0, 6, 1, 1, 1, KEY_MEDIUM, 32'h11);
        scen(6'h00, 16'h0101, 16'h0033, 1, 1, 2, 4'h2, 0, 6, 2, 1, 0, KEY_NONE, 0);
        scen(6'h00, 16'h0101, 16'h0, 1, 1, 2, 4'h2, 0, 30, 2, 1, 0, KEY_NONE, 0);
        scen(6'h20, 16'h0101, 16'h0028, 1, 0, 2, 4'h2, 0, 30, 2, 1, 0, KEY_NONE, 0);
        report_and_stop();
    end
endmodule

// file: sim/mer_medium_model.sv
// medium engine model answering recovery passes
`timescale 1ns/1ps
module mer_medium_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // retry request from the policy block, block strobe from the bench
    input wire logic retryReq,
    input wire logic blkReady,
    // scenario knobs
    input wire logic [3:0] failCount,
    input wire logic [7:0] passDelay,
    // pass results
    output logic passDone,
    output logic passOk
);
    logic [7:0] waitCnt;
    logic [3:0] nFail;
    // passOk toggles between results so a stale level is never trusted
    always @(posedge ref_clk) begin
        if (rst) begin
            waitCnt <= 8'h00;
            nFail <= 4'h0;
            passDone <= 1'b0;
            passOk <= 1'b0;
        end else begin
            passDone <= !retryReq && waitCnt == 8'h01;
            if (blkReady) begin
                nFail <= 4'h0;
            end else if (!retryReq && waitCnt == 8'h01) begin
                nFail <= nFail + 4'h1;
            end
            if (retryReq) begin
                waitCnt <= passDelay;
                passOk <= ~passOk;
            end else if (waitCnt == 8'h01) begin
                passOk <= (nFail >= failCount);
                waitCnt <= 8'h00;
            end else begin
                passOk <= ~passOk;
                if (waitCnt != 8'h00) waitCnt <= waitCnt - 8'h01;
            end
        end
    end
endmodule
